//--- bhp_pkg.sv
// Package for the bidirectional 16-bit handshake port
package bhp_pkg;
  // ******************************
  // Register byte offsets
  // ******************************
  localparam logic [7:0] ADDR_GEN_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_SVC_SEL   = 8'h04;
  localparam logic [7:0] ADDR_PA_CTRL   = 8'h18;
  localparam logic [7:0] ADDR_PB_CTRL   = 8'h1c;
  localparam logic [7:0] ADDR_PA_DATA   = 8'h20;
  localparam logic [7:0] ADDR_PB_DATA   = 8'h24;
  localparam logic [7:0] ADDR_STATUS    = 8'h34;
  // ******************************
  // Field positions and field values
  // ******************************
  localparam int GC_MODE_HI   = 7;
  localparam int GC_MODE_LO   = 6;
  localparam int GC_IN_EN     = 5;
  localparam int GC_OUT_EN    = 4;
  localparam int GC_SENSE_IRD = 3;
  localparam int GC_SENSE_ISTB = 2;
  localparam int GC_SENSE_ORD = 1;
  localparam int GC_SENSE_ACK = 0;
  localparam int CR_PULSED    = 3;
  localparam int CR_RDY_IE    = 2;
  localparam int CR_SVC_EN    = 1;
  localparam int CR_ACK_STCTL = 0;
  localparam int SS_HI        = 6;
  localparam int SS_LO        = 5;
  localparam logic [1:0] MODE_BIDIR16 = 2'h3;
  localparam logic [1:0] SVC_DMA_ACK  = 2'h2;
  localparam logic [1:0] SVC_DMA_STB  = 2'h3;
  // ******************************
  // Reset values and counts
  // ******************************
  localparam logic [7:0] RST_REG      = 8'h00;
  localparam int         PULSE_CYCLES = 4;
  localparam logic [2:0] PULSE_LEN    = 3'h4;
  typedef enum logic [1:0] {
    BHP_EMPTY,
    BHP_ONE,
    BHP_TWO
  } bhp_fill_t;
endpackage

//--- bhp_port.sv
// Bidirectional 16-bit double-buffered handshake port with Wishbone slave
// ******************************
// Notes on behaviour
// ******************************
// Notes on behaviour
// R1 - Both bytes form one double-buffered 16-bit path; two handshake pairs
// R2 - Output pair gated by output enable bit, input pair by input enable bit
// R3 - Acknowledge level alone sets direction; submode fields unused
// R4 - Drivers on while acknowledge negated, off if asserted; edges still act
// R5 - Peripheral negates acknowledge on ready, asserts it once data taken
// R6 - Strobe asserted edge captures sixteen pins into input latches
// R7 - Strobe status is one while unread input data is held
// R8 - Interlocked in-ready on while room, off after strobe; others ignored
// R9 - Pulsed input ready lasts at most four cycles, cut by new strobe
// R10 - Input ready status reads zero; input ready held off when pair disabled
// R11 - Written data enters output latch; acknowledge moves next word down
// R12 - Port A control bit 0: ack status means room, or both latches empty
// R13 - Interlocked output ready on while data waits, off after acknowledge
// R14 - Pulsed output ready at most four cycles; status zero; off if disabled
// R15 - Port A control bit 3 picks interlocked or pulsed output handshake
// R16 - Port B control bit 3 picks interlocked or pulsed input handshake
// R17 - Control bit 2 enables ready interrupt on each port
// R18 - Port A control bit 1 enables acknowledge interrupt and DMA request
// R19 - Port B control bit 1 enables strobe interrupt and DMA request
// R20 - Port A write is held until port B write moves both bytes
// R21 - Sequencing keyed to port B data access; master accesses A first
// R22 - DMA request serves one direction only; reads give final input latch
// R23 - Mode field bits 7:6 equal to 11 selects this mode
// R24 - General control bits 3:0 set sense of each handshake pin
// R25 - Select 10 binds DMA to acknowledge, 11 to strobe, without interrupt
// R26 - Handshake inputs synchronised, asserted edges detected before acting
//
// Register access over Wishbone and the register addresses were decided locally.
`timescale 1ns/1ps
module bhp_port (
  // Clock, reset, enable
  input  wire logic        CLK_SYS_I,
  input  wire logic        SYS_RST_I,
  input  wire logic        CLK_EN_I,
  // Wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // Handshake pins
  input  wire logic        OUT_ACK_IN_I,
  input  wire logic        IN_STROBE_PIN_I,
  output logic             OUT_READY_PIN_O,
  output logic             IN_READY_PIN_O,
  // Port data pins
  input  wire logic [15:0] PORT_DATA_I,
  output logic      [15:0] PORT_DATA_O,
  output logic      [15:0] PORT_DATA_OE_O,
  // Service requests
  output logic             DMA_REQUEST_PIN_O,
  output logic             PORT_IRQ_O
);
  import bhp_pkg::*;

  // ******************************
  // Input synchronisers
  // ******************************
  logic [1:0]  ack_s_q, stb_s_q;
  logic [1:0]  ack_s_d, stb_s_d;
  logic [15:0] pin_s1_q, pin_s2_q;
  logic        ack_prev_q, stb_prev_q;
  // Only the second stage feeds logic; the first may still be settling
  logic        ack_act, stb_act;

  always_comb begin
    ack_s_d = {ack_s_q[0], OUT_ACK_IN_I};
    stb_s_d = {stb_s_q[0], IN_STROBE_PIN_I};
  end

  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ack_s_q    <= 2'h0;
      stb_s_q    <= 2'h0;
      pin_s1_q   <= 16'h0000;
      pin_s2_q   <= 16'h0000;
      ack_prev_q <= 1'b0;
      stb_prev_q <= 1'b0;
    end else if (CLK_EN_I) begin
      ack_s_q    <= ack_s_d;
      stb_s_q    <= stb_s_d;
      pin_s1_q   <= PORT_DATA_I;
      pin_s2_q   <= pin_s1_q;
      ack_prev_q <= ack_act;
      stb_prev_q <= stb_act;
    end
  end

  // ******************************
  // Registers and state
  // ******************************
  logic [7:0]  gen_q, gen_d, svc_q, svc_d, pac_q, pac_d, pbc_q, pbc_d;
  logic [7:0]  tmp_hi_q, tmp_hi_d;
  logic [15:0] ol_q [2];
  logic [15:0] ol_d [2];
  logic [15:0] il_q [2];
  logic [15:0] il_d [2];
  bhp_fill_t   ocnt_q, ocnt_d, icnt_q, icnt_d;
  logic        ord_q, ord_d, ird_q, ird_d;
  logic [2:0]  opl_q, opl_d, ipl_q, ipl_d;
  logic        ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic        ack_irq_q, ack_irq_d, stb_irq_q, stb_irq_d;

  logic        ack_edge, stb_edge, o_arm, i_arm;
  logic        mode3, oen, ien, req, wr_b, rd_b;
  logic        dma_ack, dma_stb, ack_st, stb_st, o_room, i_room;
  logic        ord_on, ird_on;

  // Sense bit 1 means high is asserted, 0 means low is asserted
  function automatic logic sense(input logic lvl, input logic hi_act);
    sense = hi_act ? lvl : ~lvl;
  endfunction

  always_comb begin
    ack_act  = sense(ack_s_q[1], gen_q[GC_SENSE_ACK]);  // R24 R26
    stb_act  = sense(stb_s_q[1], gen_q[GC_SENSE_ISTB]); // R24 R26
    mode3    = gen_q[GC_MODE_HI:GC_MODE_LO] == MODE_BIDIR16; // R23
    oen      = mode3 & gen_q[GC_OUT_EN];  // R2
    ien      = mode3 & gen_q[GC_IN_EN];   // R2
    // A spent pulse stays armed: edges after its leading edge still count
    o_arm    = ord_q | (pac_q[CR_PULSED] & (opl_q == 3'h1)); // R14
    i_arm    = ird_q | (pbc_q[CR_PULSED] & (ipl_q == 3'h1)); // R9
    // Other edges are dropped while the matching ready is negated
    ack_edge = oen & ack_act & ~ack_prev_q & o_arm; // R13 R26
    stb_edge = ien & stb_act & ~stb_prev_q & i_arm; // R8 R26
    req      = WB_CYC_I & WB_STB_I & ~ack_q;
    wr_b     = req & WB_WE_I & (WB_ADR_I == ADDR_PB_DATA) & WB_SEL_I[0];
    rd_b     = req & ~WB_WE_I & (WB_ADR_I == ADDR_PB_DATA); // R21
    o_room   = ocnt_q != BHP_TWO;
    i_room   = icnt_q != BHP_TWO;
    // R12
    ack_st   = pac_q[CR_ACK_STCTL] ? (ocnt_q == BHP_EMPTY) : o_room;
    stb_st   = icnt_q != BHP_EMPTY; // R7
    dma_ack  = svc_q[SS_HI:SS_LO] == SVC_DMA_ACK; // R22 R25
    dma_stb  = svc_q[SS_HI:SS_LO] == SVC_DMA_STB; // R22 R25
  end

  // ******************************
  // Double-buffered data paths
  // ******************************
  always_comb begin
    ol_d   = ol_q;
    il_d   = il_q;
    ocnt_d = ocnt_q;
    icnt_d = icnt_q;
    // R11: acknowledge frees the final latch, next word moves down
    if (ack_edge) begin
      ol_d[0] = ol_q[1];
      ocnt_d  = (ocnt_q == BHP_TWO) ? BHP_ONE : BHP_EMPTY;
    end
    // R20 R21: port B write moves both bytes; full buffer drops the word
    if (wr_b && mode3 && ocnt_d != BHP_TWO) begin
      if (ocnt_d == BHP_EMPTY) begin
        ol_d[0] = {tmp_hi_q, WB_DAT_I[7:0]}; // R1 R11
        ocnt_d  = BHP_ONE;
      end else begin
        ol_d[1] = {tmp_hi_q, WB_DAT_I[7:0]};
        ocnt_d  = BHP_TWO;
      end
    end
    // R22: reading port B consumes the final input latch
    if (rd_b && mode3 && icnt_q != BHP_EMPTY) begin
      il_d[0] = il_q[1];
      icnt_d  = (icnt_q == BHP_TWO) ? BHP_ONE : BHP_EMPTY;
    end
    // R6: strobe edge captures pins into final or initial latch
    if (stb_edge) begin
      if (icnt_d == BHP_EMPTY) begin
        il_d[0] = pin_s2_q;
        icnt_d  = BHP_ONE;
      end else begin
        il_d[1] = pin_s2_q;
        icnt_d  = BHP_TWO;
      end
    end
  end

  // ******************************
  // Handshake ready outputs
  // ******************************
  always_comb begin
    ord_on = oen & (ocnt_d != BHP_EMPTY);
    ird_on = ien & (icnt_d != BHP_TWO);
    ord_d  = ord_q;
    opl_d  = opl_q;
    ird_d  = ird_q;
    ipl_d  = ipl_q;
    // R13 R14 R15: negate after edge, reassert once ready again
    if (!oen || ack_edge) begin
      ord_d = 1'b0; // R2 R14
      opl_d = 3'h0;
    end else if (!ord_q && ord_on && opl_q == 3'h0) begin
      ord_d = 1'b1;
      opl_d = PULSE_LEN;
    end else if (ord_q && pac_q[CR_PULSED]) begin
      // The last cycle leaves the count at one: spent, not rearmed
      opl_d = (opl_q == 3'h1) ? 3'h1 : opl_q - 3'h1;
      ord_d = opl_q != 3'h1; // R14
    end else if (!ord_q && !pac_q[CR_PULSED]) begin
      opl_d = 3'h0;
    end
    // Pulsed mode keeps a spent pulse off until an edge rearms it
    if (!oen || ack_edge) begin
      opl_d = 3'h0;
    end else if (!ord_q && pac_q[CR_PULSED] && opl_q == 3'h1) begin
      opl_d = 3'h1;
    end
    // R8 R9 R10 R16: input side mirrors the output side
    if (!ien || stb_edge) begin
      ird_d = 1'b0; // R10
      ipl_d = 3'h0;
    end else if (!ird_q && ird_on && ipl_q == 3'h0) begin
      ird_d = 1'b1;
      ipl_d = PULSE_LEN;
    end else if (ird_q && pbc_q[CR_PULSED]) begin
      ipl_d = (ipl_q == 3'h1) ? 3'h1 : ipl_q - 3'h1;
      ird_d = ipl_q != 3'h1; // R9
    end else if (!ird_q && !pbc_q[CR_PULSED]) begin
      ipl_d = 3'h0;
    end
    if (ird_q && !pbc_q[CR_PULSED] && !ird_on) begin
      ird_d = 1'b0;
    end
  end

  // ******************************
  // Wishbone register access
  // ******************************
  always_comb begin
    gen_d     = gen_q;
    svc_d     = svc_q;
    pac_d     = pac_q;
    pbc_d     = pbc_q;
    tmp_hi_d  = tmp_hi_q;
    // Registered ack: the access lands one edge before ack is seen
    ack_d     = req;
    rdat_d    = 32'h0000_0000;
    ack_irq_d = ack_irq_q | (ack_edge & ~dma_ack);
    stb_irq_d = stb_irq_q | (stb_edge & ~dma_stb);
    if (req && WB_WE_I && WB_SEL_I[0]) begin
      if (WB_ADR_I == ADDR_GEN_CTRL) begin
        gen_d = WB_DAT_I[7:0];
      end else if (WB_ADR_I == ADDR_SVC_SEL) begin
        svc_d = {1'b0, WB_DAT_I[6:0]};
      end else if (WB_ADR_I == ADDR_PA_CTRL) begin
        pac_d = WB_DAT_I[7:0];
      end else if (WB_ADR_I == ADDR_PB_CTRL) begin
        pbc_d = WB_DAT_I[7:0];
      end else if (WB_ADR_I == ADDR_PA_DATA) begin
        tmp_hi_d = WB_DAT_I[7:0]; // R20
      end else if (WB_ADR_I == ADDR_STATUS) begin
        // Write one to clear; a fresh event wins over the clear
        ack_irq_d = (ack_irq_q & ~WB_DAT_I[0]) | (ack_edge & ~dma_ack);
        stb_irq_d = (stb_irq_q & ~WB_DAT_I[2]) | (stb_edge & ~dma_stb);
      end
    end
    if (req && !WB_WE_I) begin
      if (WB_ADR_I == ADDR_GEN_CTRL) begin
        rdat_d[7:0] = gen_q;
      end else if (WB_ADR_I == ADDR_SVC_SEL) begin
        rdat_d[7:0] = svc_q;
      end else if (WB_ADR_I == ADDR_PA_CTRL) begin
        rdat_d[7:0] = pac_q;
      end else if (WB_ADR_I == ADDR_PB_CTRL) begin
        rdat_d[7:0] = pbc_q;
      end else if (WB_ADR_I == ADDR_PA_DATA) begin
        rdat_d[7:0] = il_q[0][15:8]; // R22
      end else if (WB_ADR_I == ADDR_PB_DATA) begin
        rdat_d[7:0] = il_q[0][7:0];  // R22
      end else if (WB_ADR_I == ADDR_STATUS) begin
        // Ready status bits 1 and 3 always read zero
        rdat_d[7:0] = {4'h0, 1'b0, stb_st, 1'b0, ack_st}; // R10 R14
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      gen_q     <= RST_REG;
      svc_q     <= RST_REG;
      pac_q     <= RST_REG;
      pbc_q     <= RST_REG;
      tmp_hi_q  <= RST_REG;
      ol_q      <= '{16'h0000, 16'h0000};
      il_q      <= '{16'h0000, 16'h0000};
      ocnt_q    <= BHP_EMPTY;
      icnt_q    <= BHP_EMPTY;
      ord_q     <= 1'b0;
      ird_q     <= 1'b0;
      opl_q     <= 3'h0;
      ipl_q     <= 3'h0;
      ack_q     <= 1'b0;
      rdat_q    <= 32'h0000_0000;
      ack_irq_q <= 1'b0;
      stb_irq_q <= 1'b0;
    end else if (CLK_EN_I) begin
      gen_q     <= gen_d;
      svc_q     <= svc_d;
      pac_q     <= pac_d;
      pbc_q     <= pbc_d;
      tmp_hi_q  <= tmp_hi_d;
      ol_q      <= ol_d;
      il_q      <= il_d;
      ocnt_q    <= ocnt_d;
      icnt_q    <= icnt_d;
      ord_q     <= ord_d;
      ird_q     <= ird_d;
      opl_q     <= opl_d;
      ipl_q     <= ipl_d;
      ack_q     <= ack_d;
      rdat_q    <= rdat_d;
      ack_irq_q <= ack_irq_d;
      stb_irq_q <= stb_irq_d;
    end
  end

  // ******************************
  // Registered pin outputs
  // ******************************
  logic        ordp_q, irdp_q, dma_q, irq_q;
  logic [15:0] pdo_q, poe_q;
  logic        dma_d, irq_d;

  always_comb begin
    // R18 R19 R22: DMA request tracks output room or held input data of the bound direction
    dma_d = (dma_ack & pac_q[CR_SVC_EN] & oen & o_room)
          | (dma_stb & pbc_q[CR_SVC_EN] & ien & stb_st);
    irq_d = (ack_irq_q & pac_q[CR_SVC_EN] & ~dma_ack)   // R18 R25
          | (stb_irq_q & pbc_q[CR_SVC_EN] & ~dma_stb)   // R19 R25
          | (ord_q & pac_q[CR_RDY_IE])                  // R17
          | (ird_q & pbc_q[CR_RDY_IE]);                 // R17
  end

  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      // Ready pins show the negated level of the low-true reset sense
      ordp_q <= 1'b1;
      irdp_q <= 1'b1;
      pdo_q  <= 16'h0000;
      poe_q  <= 16'h0000;
      dma_q  <= 1'b0;
      irq_q  <= 1'b0;
    end else if (CLK_EN_I) begin
      // Ready pins carry one cycle of latency behind state
      ordp_q <= ord_q ~^ gen_q[GC_SENSE_ORD]; // R24
      irdp_q <= ird_q ~^ gen_q[GC_SENSE_IRD]; // R24
      pdo_q  <= ol_q[0];
      // R3 R4: acknowledge level alone sets direction
      // Drivers trail the pin by the two synchroniser flops and this one
      poe_q  <= {16{mode3 & ~ack_act}};
      dma_q  <= dma_d;
      irq_q  <= irq_d;
    end
  end

  always_comb begin
    WB_DAT_O          = rdat_q;
    WB_ACK_O          = ack_q;
    OUT_READY_PIN_O   = ordp_q;
    IN_READY_PIN_O    = irdp_q;
    PORT_DATA_O       = pdo_q;
    PORT_DATA_OE_O    = poe_q;
    DMA_REQUEST_PIN_O = dma_q;
    PORT_IRQ_O        = irq_q;
  end
endmodule

//--- bhp_port_sva.sv
// Assertion checker for the handshake port bus and pin outputs
`timescale 1ns/1ps
module bhp_port_sva
  import bhp_pkg::*;
(
  input wire logic        CLK_SYS_I,
  input wire logic        SYS_RST_I,
  input wire logic        CLK_EN_I,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic [15:0] PORT_DATA_OE_O,
  input wire logic        OUT_READY_PIN_O,
  input wire logic        DMA_REQUEST_PIN_O,
  input wire logic        PORT_IRQ_O
);
  // ******************************
  // Properties
  // ******************************
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);
  logic rd_ack;
  assign rd_ack = WB_ACK_O && !WB_WE_I;
  a_ack_answer: assert property (
    WB_CYC_I && WB_STB_I && !WB_ACK_O && CLK_EN_I |=> WB_ACK_O)
    else $error("request not answered next cycle");
  a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  a_no_spurious_ack: assert property (!(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O)
    else $error("ack without request");
  a_read_upper_zero: assert property (rd_ack |-> WB_DAT_O[31:8] == 24'h0)
    else $error("read data above byte not zero");
  a_status_ready_zero: assert property (
    rd_ack && WB_ADR_I == ADDR_STATUS |-> !WB_DAT_O[1] && !WB_DAT_O[3])
    else $error("ready status bit not zero");
  a_null_read: assert property (rd_ack && WB_ADR_I == 8'h08 |-> WB_DAT_O == 0)
    else $error("unmapped read not zero");
  a_drivers_all16: assert property (
    PORT_DATA_OE_O != 16'h0 |-> PORT_DATA_OE_O == 16'hffff)
    else $error("port drivers not switched together");
  a_reset_quiet: assert property (
    $fell(SYS_RST_I) |-> !WB_ACK_O && !DMA_REQUEST_PIN_O && !PORT_IRQ_O)
    else $error("outputs active after reset");
  c_out_ready: cover property ($rose(OUT_READY_PIN_O));
  c_dma: cover property ($rose(DMA_REQUEST_PIN_O));
  c_irq: cover property ($rose(PORT_IRQ_O));
endmodule
bind bhp_port bhp_port_sva u_sva (.CLK_SYS_I(CLK_SYS_I),
  .SYS_RST_I(SYS_RST_I), .CLK_EN_I(CLK_EN_I), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .PORT_DATA_OE_O(PORT_DATA_OE_O),
  .OUT_READY_PIN_O(OUT_READY_PIN_O), .DMA_REQUEST_PIN_O(DMA_REQUEST_PIN_O),
  .PORT_IRQ_O(PORT_IRQ_O));

//--- bhp_periph.sv
// Peripheral model for the far side of the handshake port
`timescale 1ns/1ps
module bhp_periph (
  // Control from bench
  input  wire logic        clk_i,
  input  wire logic        stall_i,
  // Pins from port
  input  wire logic        out_ready_i,
  input  wire logic        in_ready_i,
  input  wire logic [15:0] data_i,
  input  wire logic [15:0] oe_i,
  // Pins to port
  output logic             ack_o,
  output logic             strobe_o,
  output logic      [15:0] data_o
);
  // ******************************
  // Handshake behaviour
  // ******************************
  // Senses assumed active high; ready is remembered so a short pulse counts
  logic [15:0] got[$];
  logic        pend;
  logic        tmo;
  initial begin
    ack_o = 1'b1;
    strobe_o = 1'b0;
    data_o = 16'h0;
    pend = 1'b0;
    tmo = 1'b0;
  end
  always begin
    @(posedge clk_i);
    if (out_ready_i === 1'b1) pend = 1'b1;
    if (pend && !stall_i) begin
      pend = 1'b0;
      ack_o <= 1'b0;
      repeat (5) @(posedge clk_i);
      got.push_back(oe_i === 16'hffff ? data_i : ~data_i);
      ack_o <= 1'b1;
      repeat (8) @(posedge clk_i);
    end
  end
  // Skipping the wait sends a strobe that the port must ignore
  task automatic send(input logic [15:0] w, input bit wt);
    int i;
    for (i = 0; wt && i < 200 && in_ready_i !== 1'b1; i++) @(posedge clk_i);
    if (wt && in_ready_i !== 1'b1) tmo = 1'b1;
    data_o <= w;
    repeat (3) @(posedge clk_i);
    strobe_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    strobe_o <= 1'b0;
    repeat (3) @(posedge clk_i);
    data_o <= ~w;
  endtask
endmodule

//--- test_bidir_16bit_handshake_port.sv
// Self-checking bench for the bidirectional 16-bit handshake port
`timescale 1ns/1ps
module test_bidir_16bit_handshake_port;
  import bhp_pkg::*;
  // ******************************
  // Signals, tasks and sequence
  // ******************************
  logic        clk = 1'b0, rst = 1'b1, stall = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h0;
  logic [31:0] dw = 32'h0, dr, rd;
  logic        ack, ordy, irdy, ack_p, stb_p, dma, irq;
  logic [15:0] pdo, poe, pdi;
  logic [7:0]  regs[5] = '{ADDR_GEN_CTRL, ADDR_SVC_SEL, ADDR_PA_CTRL,
                           ADDR_PB_CTRL, 8'h08};
  logic [7:0]  ein[4] = '{8'h11, 8'h11, 8'h22, 8'h22};
  int          failures = 0, n_checks = 0, i, n;
  always #25 clk = ~clk;
  bhp_port dut (.CLK_SYS_I(clk), .SYS_RST_I(rst), .CLK_EN_I(1'b1),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(4'h1), .WB_DAT_I(dw), .WB_DAT_O(dr), .WB_ACK_O(ack),
    .OUT_ACK_IN_I(ack_p), .IN_STROBE_PIN_I(stb_p), .OUT_READY_PIN_O(ordy),
    .IN_READY_PIN_O(irdy), .PORT_DATA_I(pdi), .PORT_DATA_O(pdo),
    .PORT_DATA_OE_O(poe), .DMA_REQUEST_PIN_O(dma), .PORT_IRQ_O(irq));
  bhp_periph p (.clk_i(clk), .stall_i(stall), .out_ready_i(ordy),
    .in_ready_i(irdy), .data_i(pdo), .oe_i(poe), .ack_o(ack_p),
    .strobe_o(stb_p), .data_o(pdi));
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic bound(input int k);
    if (k >= 300) begin
      failures++;
      tally_and_finish();
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= {24'h0, d};
    for (n = 0; n < 300; n++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    rd = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    bound(n);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h0);
    chk(rd, {24'h0, e});
  endtask
  initial begin
    tick(20);
    rst <= 1'b0;
    foreach (regs[k]) rdc(regs[k], RST_REG);
    wb(1'b1, ADDR_GEN_CTRL, 8'hcf);
    tick(6);
    chk({ordy, irdy}, 2'b00);
    wb(1'b1, ADDR_GEN_CTRL, 8'hff);
    rdc(ADDR_GEN_CTRL, 8'hff);
    // Lone high byte must not start a transfer
    wb(1'b1, ADDR_PA_DATA, 8'h12);
    tick(8);
    chk(ordy, 1'b0);
    wb(1'b1, ADDR_PB_DATA, 8'h34);
    rdc(ADDR_STATUS, 8'h01);
    wb(1'b1, ADDR_PA_DATA, 8'h56);
    wb(1'b1, ADDR_PB_DATA, 8'h78);
    rdc(ADDR_STATUS, 8'h00);
    wb(1'b1, ADDR_PA_CTRL, 8'h01);
    rdc(ADDR_STATUS, 8'h00);
    // Third word while both latches hold data is dropped
    wb(1'b1, ADDR_PA_DATA, 8'hde);
    wb(1'b1, ADDR_PB_DATA, 8'had);
    stall <= 1'b0;
    for (i = 0; i < 300 && p.got.size() < 2; i++) tick(1);
    bound(i);
    tick(30);
    chk(p.got.size(), 2);
    chk(p.got[0], 16'h1234);
    chk(p.got[1], 16'h5678);
    chk(ordy, 1'b0);
    rdc(ADDR_STATUS, 8'h01);
    // Pulsed ready with the peripheral stalled
    wb(1'b1, ADDR_PA_CTRL, 8'h08);
    stall <= 1'b1;
    wb(1'b1, ADDR_PA_DATA, 8'h9a);
    wb(1'b1, ADDR_PB_DATA, 8'hbc);
    for (i = 0; i < 300 && ordy !== 1'b1; i++) tick(1);
    bound(i);
    for (n = 0; n < 9 && ordy === 1'b1; n++) tick(1);
    chk(n, 4);
    stall <= 1'b0;
    for (i = 0; i < 300 && p.got.size() < 3; i++) tick(1);
    bound(i);
    chk(p.got[2], 16'h9abc);
    // Fill input path, then a strobe with ready negated
    p.send(16'h1111, 1'b1);
    p.send(16'h2222, 1'b1);
    p.send(16'h3333, 1'b0);
    rdc(ADDR_STATUS, 8'h05);
    foreach (ein[k]) begin
      rdc((k % 2 != 0) ? ADDR_PB_DATA : ADDR_PA_DATA, ein[k]);
    end
    rdc(ADDR_STATUS, 8'h01);
    // Strobe transfers bound to the DMA request
    wb(1'b1, ADDR_SVC_SEL, 8'h60);
    wb(1'b1, ADDR_PB_CTRL, 8'h02);
    rdc(ADDR_PB_CTRL, 8'h02);
    p.send(16'h4455, 1'b1);
    for (i = 0; i < 300 && dma !== 1'b1; i++) tick(1);
    bound(i);
    chk(irq, 1'b0);
    rdc(ADDR_PA_DATA, 8'h44);
    rdc(ADDR_PB_DATA, 8'h55);
    // Strobe interrupt, then its enable removed
    wb(1'b1, ADDR_SVC_SEL, 8'h00);
    wb(1'b1, ADDR_STATUS, 8'h05);
    p.send(16'h6677, 1'b1);
    for (i = 0; i < 300 && irq !== 1'b1; i++) tick(1);
    bound(i);
    chk(dma, 1'b0);
    wb(1'b1, ADDR_PB_CTRL, 8'h00);
    tick(3);
    chk(irq, 1'b0);
    wb(1'b1, ADDR_PB_CTRL, 8'h04);
    tick(3);
    chk(irq, 1'b1);
    chk(p.tmo, 1'b0);
    tally_and_finish();
  end
endmodule
